// ### rtl/mvf_formatter.sv
`timescale 1ns/1ps
module mvf_formatter import mvf_pkg::*; (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pixel clock from the link side
	input wire logic pix_clk,
	// Frame control
	input wire logic frame_start,
	input wire logic [1:0] mode_sel,
	input wire logic [WIDTH_W-1:0] roi_width,
	input wire logic [HEIGHT_W-1:0] roi_height,
	// Sample source
	input wire logic [LANE_BUS_W-1:0] src_samples,
	output logic src_take,
	// Video output
	output logic fval,
	output logic lval,
	output logic [LANE_BUS_W-1:0] lane_data,
	output logic busy
);
	logic pclk_s1_r;
	logic pclk_s2_r;
	logic pclk_s3_r;
	logic tick;
	logic pend_r;
	logic start_go;
	mvf_state_type state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [HEIGHT_W-1:0] line_left_r;
	mvf_mode_type mode_r;
	mvf_mode_type mode_nxt;
	logic [CNT_W-1:0] beats_r;
	logic [CNT_W-1:0] beats_nxt;
	logic [HEIGHT_W-1:0] lines_r;
	logic [HEIGHT_W-1:0] lines_nxt;
	logic [CNT_W-1:0] lead_nxt;
	logic [CNT_W-1:0] gap_r;
	logic [CNT_W-1:0] gap_nxt;
	logic [WIDTH_W-1:0] width_c;
	logic fval_r;
	logic lval_r;
	logic take_r;
	logic busy_r;
	logic launch;
	logic [LANE_BUS_W-1:0] lane_r;
	mvf_lane_if lk ();

	// Pixel clock synchroniser and rising edge finder
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pclk_s1_r <= 1'b0;
			pclk_s2_r <= 1'b0;
			pclk_s3_r <= 1'b0;
		end else begin
			pclk_s1_r <= pix_clk;
			pclk_s2_r <= pclk_s1_r;
			pclk_s3_r <= pclk_s2_r;
		end
	end
	assign tick = pclk_s2_r & ~pclk_s3_r;

	// Start request held until the sequencer is free
	assign start_go = tick && (state_r == ST_IDLE) && pend_r;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pend_r <= 1'b0;
		end else if (frame_start) begin
			pend_r <= 1'b1;
		end else if (start_go) begin
			pend_r <= 1'b0;
		end
	end

	// Frame geometry from mode and area of interest
	always_comb begin
		case (mode_sel)
			2'h1: mode_nxt = MODE_4T8;
			2'h2: mode_nxt = MODE_8T8;
			default: mode_nxt = MODE_4T10;
		endcase
		if ((roi_width == '0) || (roi_width > MAX_WIDTH)) begin
			width_c = MAX_WIDTH;
		end else begin
			width_c = roi_width;
		end
		if ((roi_height == '0) || (roi_height > MAX_HEIGHT)) begin
			lines_nxt = MAX_HEIGHT;
		end else begin
			lines_nxt = roi_height;
		end
		if (mode_nxt == MODE_8T8) begin
			beats_nxt = CNT_W'((width_c + WIDTH_W'(TAPS_MAX - 1))
				>> SHIFT_EIGHT);
			lead_nxt = LEAD_EIGHT_CLKS;
			gap_nxt = GAP_EIGHT_CLKS;
		end else begin
			beats_nxt = CNT_W'((width_c + WIDTH_W'(TAPS_FOUR - 1))
				>> SHIFT_FOUR);
			lead_nxt = LEAD_FOUR_CLKS;
			gap_nxt = GAP_FOUR_CLKS;
		end
	end

	// Frame settings frozen for the whole frame
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= MODE_4T10;
			beats_r <= '0;
			lines_r <= '0;
			gap_r <= '0;
		end else if (start_go) begin
			mode_r <= mode_nxt;
			beats_r <= beats_nxt;
			lines_r <= lines_nxt;
			gap_r <= gap_nxt;
		end
	end

	// A beat goes out on this pixel edge
	assign launch = tick && ((((state_r == ST_LEAD) ||
		(state_r == ST_GAP)) && (cnt_r == CNT_ONE)) ||
		((state_r == ST_LINE) && (cnt_r != CNT_ONE)));

	// Frame and line sequencer
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			line_left_r <= '0;
			fval_r <= 1'b0;
			lval_r <= 1'b0;
		end else if (tick) begin
			case (state_r)
				ST_IDLE: begin
					fval_r <= 1'b0;
					lval_r <= 1'b0;
					if (pend_r) begin
						state_r <= ST_LEAD;
						cnt_r <= lead_nxt;
						line_left_r <= lines_nxt;
						fval_r <= 1'b1;
					end
				end
				ST_LEAD: begin
					if (cnt_r == CNT_ONE) begin
						state_r <= ST_LINE;
						cnt_r <= beats_r;
						lval_r <= 1'b1;
					end else begin
						cnt_r <= cnt_r - CNT_ONE;
					end
				end
				ST_LINE: begin
					if (cnt_r != CNT_ONE) begin
						cnt_r <= cnt_r - CNT_ONE;
					end else if (line_left_r == HEIGHT_W'(1)) begin
						state_r <= ST_IDLE;
						fval_r <= 1'b0;
						lval_r <= 1'b0;
					end else begin
						state_r <= ST_GAP;
						cnt_r <= gap_r;
						line_left_r <= line_left_r - HEIGHT_W'(1);
						lval_r <= 1'b0;
					end
				end
				ST_GAP: begin
					if (cnt_r == CNT_ONE) begin
						state_r <= ST_LINE;
						cnt_r <= beats_r;
						lval_r <= 1'b1;
					end else begin
						cnt_r <= cnt_r - CNT_ONE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					fval_r <= 1'b0;
					lval_r <= 1'b0;
				end
			endcase
		end
	end

	// Lane formatting through the packer
	assign lk.mode = mode_r;
	assign lk.samples = src_samples;
	mvf_tap_packer u_packer (
		.lk(lk.pack)
	);

	// Lane register, zero outside active beats
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lane_r <= '0;
		end else if (tick) begin
			lane_r <= launch ? lk.lanes : '0;
		end
	end

	// Source advance strobe after each beat
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			take_r <= 1'b0;
		end else begin
			take_r <= launch;
		end
	end

	// Busy flag for the capture side
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= pend_r || (state_r != ST_IDLE);
		end
	end

	// Outputs from flip-flops
	assign fval = fval_r;
	assign lval = lval_r;
	assign lane_data = lane_r;
	assign src_take = take_r;
	assign busy = busy_r;

	// Helper counters of pixel edges per phase
	logic [CNT_W-1:0] lead_seen_r;
	logic [CNT_W-1:0] gap_seen_r;
	logic [CNT_W-1:0] beat_seen_r;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lead_seen_r <= '0;
			gap_seen_r <= '0;
			beat_seen_r <= '0;
		end else if (tick) begin
			lead_seen_r <= (state_r == ST_LEAD) ?
				lead_seen_r + CNT_ONE : '0;
			gap_seen_r <= (state_r == ST_GAP) ?
				gap_seen_r + CNT_ONE : '0;
			beat_seen_r <= (state_r == ST_LINE) ?
				beat_seen_r + CNT_ONE : '0;
		end
	end
	logic [CNT_W-1:0] lead_want;
	assign lead_want = (mode_r == MODE_8T8) ?
		LEAD_EIGHT_CLKS : LEAD_FOUR_CLKS;

	// Launch step: pixel edge then output update
	sequence s_edge_seen;
		$past(tick);
	endsequence
	sequence s_line_open;
		$rose(lval_r) ##0 (line_left_r == lines_r);
	endsequence

	property p_launch_on_edge;
		@(posedge clk_sys) disable iff (!reset_n)
		($changed(lval_r) || $changed(fval_r)) |-> s_edge_seen;
	endproperty
	a_launch_on_edge: assert property (p_launch_on_edge)
		else $error("valid bits changed without a pixel edge");

	property p_first_lead;
		@(posedge clk_sys) disable iff (!reset_n)
		s_line_open |-> (lead_seen_r == lead_want);
	endproperty
	a_first_lead_gap: assert property (p_first_lead)
		else $error("first line valid delay is wrong");

	a_line_beat_count: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(lval_r) |-> (beat_seen_r == beats_r))
		else $error("line length differs from beat count");

	a_line_gap_len: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		($rose(lval_r) && ($past(state_r) == ST_GAP))
		|-> (gap_seen_r == gap_r))
		else $error("inter-line gap has wrong length");

	a_lval_in_fval: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		lval_r |-> fval_r)
		else $error("line valid high outside frame valid");

	a_frame_end_low: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(fval_r) |-> (!lval_r && $past(line_left_r) == HEIGHT_W'(1)))
		else $error("frame ended early or with line valid");

	a_idle_low: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == ST_IDLE) |-> (!fval_r && !lval_r))
		else $error("valid bits high while idle");

	a_lanes_quiet: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!lval_r |-> (lane_r == '0))
		else $error("lanes carry data outside a line");

	a_depth_narrow: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		($past(launch) && mode_r != MODE_4T10) |->
		(lane_r[NARROW_W-1:0] ==
			$past(src_samples[SAMPLE_W-1:DROP_BITS])))
		else $error("eight-bit lane not the sample top bits");

	a_depth_full: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		($past(launch) && mode_r == MODE_4T10) |->
		(lane_r[SAMPLE_W-1:0] == $past(src_samples[SAMPLE_W-1:0])))
		else $error("ten-bit lane altered the sample");

	a_four_tap_lanes: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(mode_r != MODE_8T8) |->
		(lane_r[LANE_BUS_W-1:TAPS_FOUR*SAMPLE_W] == '0))
		else $error("upper lanes active in four-tap mode");

	a_take_pulse: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		take_r |=> !take_r)
		else $error("source advance strobe longer than a cycle");

	// Frame and pending-start bookkeeping
	a_frame_held: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r != ST_IDLE) |-> fval_r)
		else $error("frame valid low inside a frame");

	a_start_kept: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		frame_start |=> pend_r)
		else $error("start request lost");

	a_idle_lanes: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!fval_r |-> (lane_r == '0))
		else $error("lanes carry data outside a frame");

	// Geometry never beyond the largest image
	a_eight_tap_width: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(mode_r == MODE_8T8) |->
		(beats_r <= CNT_W'(MAX_WIDTH >> SHIFT_EIGHT)))
		else $error("eight-tap line longer than allowed");

	a_four_tap_width: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(mode_r != MODE_8T8) |->
		(beats_r <= CNT_W'(MAX_WIDTH >> SHIFT_FOUR)))
		else $error("four-tap line longer than allowed");

	a_height_bound: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		lines_r <= MAX_HEIGHT)
		else $error("frame taller than allowed");
endmodule // mvf_formatter

// ### rtl/mvf_pkg.sv
// Overview of operation
// - Three modes: 4x10, 4x8, 8x8 bit
// - Four-tap: four pixels plus both valid bits
// - Ten-bit mode passes samples unchanged
// - Eight-bit modes drop two lowest bits
// - Eight-tap: eight pixels plus both valids
// - Outputs launch on pixel clock rising edge
// - Lanes meaningful only with both valids high
// - Up to 2352 by 1726 at 50 MHz
// - Eight-tap full line: at most 294 cycles
// - Lines top to bottom, pixels ascending
// - Both valids low when no video
// - New capture may overlap ongoing streaming
// - Eight-tap: line valid 23 clocks after frame
// - Eight-tap lane k carries pixel k+1, +8
// - Eight-tap inter-line gap is fixed
// - Both valids low after last line
// - Four-tap modes share common sequencing
// - Area of interest shrinks line and frame
// - Four-tap: line valid 24 clocks after frame
// - Four-tap full line: at most 588 cycles
// - Four-tap inter-line gap is eight clocks
// - Four-tap lane k carries pixel k+1, +4
package mvf_pkg;
	// Sample and lane geometry
	localparam int SAMPLE_W = 10;
	localparam int NARROW_W = 8;
	localparam int DROP_BITS = SAMPLE_W - NARROW_W;
	localparam int TAPS_MAX = 8;
	localparam int TAPS_FOUR = 4;
	localparam int LANE_BUS_W = TAPS_MAX * SAMPLE_W;
	localparam int SHIFT_FOUR = 2;
	localparam int SHIFT_EIGHT = 3;
	// Image size limits
	localparam int WIDTH_W = 12;
	localparam int HEIGHT_W = 11;
	localparam logic [11:0] MAX_WIDTH = 12'h930;
	localparam logic [10:0] MAX_HEIGHT = 11'h6BE;
	// Pixel clock timing, times in ns
	localparam int PIX_PERIOD_NS = 20;
	localparam int LEAD_FOUR_NS = 480;
	localparam int LEAD_EIGHT_NS = 460;
	localparam int CNT_W = 12;
	localparam logic [11:0] LEAD_FOUR_CLKS =
		12'(LEAD_FOUR_NS / PIX_PERIOD_NS);
	localparam logic [11:0] LEAD_EIGHT_CLKS =
		12'(LEAD_EIGHT_NS / PIX_PERIOD_NS);
	localparam logic [11:0] GAP_FOUR_CLKS = 12'h008;
	localparam logic [11:0] GAP_EIGHT_CLKS = 12'h007;
	localparam logic [11:0] CNT_ONE = 12'h001;
	// Output formats
	typedef enum logic [1:0] {
		MODE_4T10,
		MODE_4T8,
		MODE_8T8
	} mvf_mode_type;
	// Sequencer states
	typedef enum {
		ST_IDLE,
		ST_LEAD,
		ST_LINE,
		ST_GAP
	} mvf_state_type;
endpackage

// ### rtl/mvf_lane_if.sv
`timescale 1ns/1ps
interface mvf_lane_if;
	import mvf_pkg::*;
	mvf_mode_type mode;
	logic [LANE_BUS_W-1:0] samples;
	logic [LANE_BUS_W-1:0] lanes;
	// Formatter side drives mode and samples
	modport fmt (output mode, output samples, input lanes);
	// Packer side returns lane values
	modport pack (input mode, input samples, output lanes);
endinterface

// ### rtl/mvf_tap_packer.sv
`timescale 1ns/1ps
module mvf_tap_packer import mvf_pkg::*; (
	// Lane link
	mvf_lane_if.pack lk
);
	logic four_tap;
	logic narrow;

	// Mode decode
	assign four_tap = (lk.mode != MODE_8T8);
	assign narrow = (lk.mode != MODE_4T10);

	// Per-lane depth selection, sample k onto lane k
	genvar k;
	generate
		for (k = 0; k < TAPS_MAX; k++) begin : g_lane
			logic [SAMPLE_W-1:0] smp;
			assign smp = lk.samples[k*SAMPLE_W +: SAMPLE_W];
			always_comb begin
				if (four_tap && (k >= TAPS_FOUR)) begin
					lk.lanes[k*SAMPLE_W +: SAMPLE_W] = '0;
				end else if (narrow) begin
					lk.lanes[k*SAMPLE_W +: SAMPLE_W] =
						{{DROP_BITS{1'b0}}, smp[SAMPLE_W-1:DROP_BITS]};
				end else begin
					lk.lanes[k*SAMPLE_W +: SAMPLE_W] = smp;
				end
			end
		end
	endgenerate
endmodule // mvf_tap_packer

// ### verification/mvf_grabber_model.sv
`timescale 1ns/1ps
module mvf_grabber_model import mvf_pkg::*; (
	// Link clock and clear
	pix_clk,
	clr,
	// Video from the formatter
	fval,
	lval,
	lane_data,
	// Measured figures
	lead,
	gap,
	beats,
	lines,
	frames
);
	input wire logic pix_clk;
	input wire logic clr;
	input wire logic fval;
	input wire logic lval;
	input wire logic [LANE_BUS_W-1:0] lane_data;
	output int lead;
	output int gap;
	output int beats;
	output int lines;
	output int frames;
	logic fval_q;
	logic lval_q;
	logic first;
	int run;
	logic [LANE_BUS_W-1:0] beat_q[$];
	// Receiver samples on the rising pixel edge
	always @(posedge pix_clk or posedge clr) begin
		if (clr) begin
			{lead, gap, beats, lines, frames, run} = '0;
			{fval_q, lval_q, first} = 3'h0;
			beat_q.delete();
		end else begin
			if (fval && !fval_q) begin
				frames++;
				run = 0;
				first = 1'h1;
			end
			if (fval && !lval)
				run++;
			// Lanes kept only with both valids high
			if (fval && lval) begin
				if (!lval_q) begin
					lines++;
					if (first)
						lead = run;
					else
						gap = run;
					first = 1'h0;
					run = 0;
					beats = 0;
				end
				beats++;
				beat_q.push_back(lane_data);
			end
			fval_q = fval;
			lval_q = lval;
		end
	end
endmodule // mvf_grabber_model

// ### verification/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	mismatches++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	import mvf_pkg::*;
	logic clk_sys, reset_n, pix_clk, frame_start, clr;
	logic [1:0] mode_sel;
	logic [WIDTH_W-1:0] roi_width;
	logic [HEIGHT_W-1:0] roi_height;
	logic [LANE_BUS_W-1:0] src_samples, lane_data;
	logic src_take, fval, lval, busy;
	int mismatches, checks, grp, lead, gap, beats, lines, frames;
	// Device under test
	mvf_formatter dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.pix_clk(pix_clk), .frame_start(frame_start),
		.mode_sel(mode_sel), .roi_width(roi_width),
		.roi_height(roi_height), .src_samples(src_samples),
		.src_take(src_take), .fval(fval), .lval(lval),
		.lane_data(lane_data), .busy(busy));
	// Frame grabber on the far side
	mvf_grabber_model fg (.pix_clk(pix_clk), .clr(clr), .fval(fval),
		.lval(lval), .lane_data(lane_data), .lead(lead), .gap(gap),
		.beats(beats), .lines(lines), .frames(frames));
	// Sample pattern with busy low bits
	function automatic logic [9:0] pix(int g, int k);
		return 10'((g * 8 + k) * 29 + 3);
	endfunction
	function automatic logic [LANE_BUS_W-1:0] exp_beat(int g, int taps,
		logic narrow);
		logic [LANE_BUS_W-1:0] v;
		logic [9:0] s;
		v = '0;
		for (int k = 0; k < taps; k++) begin
			s = pix(g, k);
			v[k*10 +: 10] = narrow ? {2'h0, s[9:2]} : s;
		end
		return v;
	endfunction
	// Clocks: system 10 ns, pixel 125 ns
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		pix_clk = 1'h0;
		#3.3;
		forever #62.5 pix_clk = ~pix_clk;
	end
	// Source presents the next group after each take
	always_comb
		for (int k = 0; k < TAPS_MAX; k++)
			src_samples[k*10 +: 10] = pix(grp, k);
	always @(negedge clk_sys)
		if (src_take === 1'h1)
			grp++;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One or two frames in a mode, checked at the grabber
	task automatic run_frame(logic [1:0] m, int w, int h, bit twice);
		int taps, we, nb, n;
		logic narrow;
		taps = (m == 2'h2) ? 8 : 4;
		narrow = (m == 2'h1) || (m == 2'h2);
		we = (w == 0 || w > 2352) ? 2352 : w;
		nb = (we + taps - 1) / taps;
		@(negedge clk_sys);
		grp = 0;
		clr = 1'h1;
		mode_sel = m;
		roi_width = WIDTH_W'(w);
		roi_height = HEIGHT_W'(h);
		frame_start = 1'h1;
		@(negedge clk_sys);
		clr = 1'h0;
		frame_start = 1'h0;
		for (n = 0; n < 20 && busy !== 1'h1; n++)
			@(negedge clk_sys);
		`CHK("busy", 1'h1, busy)
		if (twice) begin
			repeat (60) @(negedge clk_sys);
			frame_start = 1'h1;
			@(negedge clk_sys);
			frame_start = 1'h0;
		end
		for (n = 0; n < 20000 && busy !== 1'h0; n++)
			@(negedge clk_sys);
		if (n == 20000)
			mismatches++;
		repeat (40) @(negedge clk_sys);
		`CHK("lead", (taps == 8) ? 23 : 24, lead)
		if (h > 1)
			`CHK("gap", (taps == 8) ? 7 : 8, gap)
		`CHK("beats", nb, beats)
		`CHK("lines", twice ? 2 * h : h, lines)
		`CHK("frames", twice ? 2 : 1, frames)
		`CHK("count", (twice ? 2 * h : h) * nb, fg.beat_q.size())
		for (int i = 0; i < fg.beat_q.size(); i++)
			`CHK("lanes", exp_beat(i, taps, narrow), fg.beat_q[i])
		`CHK("idle", 83'h0, {busy, fval, lval, lane_data})
	endtask
	// Watchdog
	initial begin
		#600us;
		mismatches++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		{reset_n, frame_start, clr} = 3'h0;
		mode_sel = 2'h0;
		roi_width = '0;
		roi_height = '0;
		grp = 0;
		repeat (20) @(negedge clk_sys);
		reset_n = 1'h1;
		@(negedge clk_sys);
		run_frame(2'h0, 20, 3, 1'b0);
		run_frame(2'h1, 18, 2, 1'b0);
		run_frame(2'h2, 17, 3, 1'b0);
		run_frame(2'h3, 9, 2, 1'b0);
		run_frame(2'h2, 24, 2, 1'b1);
		run_frame(2'h0, 8, 2, 1'b1);
		run_frame(2'h2, 0, 1, 1'b0);
		tally_and_finish();
	end
endmodule // testbench
